// *** css_pkg.sv ***
// constants, register map and state type of the charge state sequencer
package css_pkg;
  // clock and internal oscillator timing
  localparam int          CLK_PERIOD_NS = 5;
  localparam int          OSC_PERIOD_NS = 20000;
  localparam int          OSC_DIV_W     = 16;
  localparam logic [15:0] OSC_DIV_RST   =
    16'((OSC_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [15:0] OSC_DIV_MIN   = 16'h0002;
  // charge-time counter: full limit in oscillator periods, trickle 1/8
  localparam int          TIMEOUT_OSC   = 4194304;
  localparam int          TMR_W         = 23;
  localparam int          TRICKLE_SHIFT = 3;
  // register word indices on the plain register port
  localparam int          ADDR_W        = 4;
  localparam logic [3:0]  ADDR_STATE    = 4'h0;
  localparam logic [3:0]  ADDR_TIMER    = 4'h1;
  localparam logic [3:0]  ADDR_OSC_DIV  = 4'h2;
  localparam logic [3:0]  ADDR_IRQ_STAT = 4'h3;
  localparam logic [3:0]  ADDR_IRQ_MASK = 4'h4;
  // state register field positions
  localparam int          ST_STATE_LSB  = 0;
  localparam int          ST_STATUS     = 3;
  localparam int          ST_FAULT      = 4;
  localparam int          ST_CHARGE     = 5;
  localparam int          ST_RECHG      = 6;
  localparam int          ST_TEMP_BAD   = 7;
  localparam int          ST_STAT_PIN   = 8;
  localparam int          ST_FAULT_PIN  = 9;
  // interrupt status and mask bits
  localparam int          IRQ_W         = 4;
  localparam int          IRQ_FAULT     = 0;
  localparam int          IRQ_EOC       = 1;
  localparam int          IRQ_RECHG     = 2;
  localparam int          IRQ_TEMP      = 3;
  localparam logic [3:0]  IRQ_MASK_RST  = 4'h0;
  localparam logic [3:0]  IRQ_STAT_RST  = 4'h0;
  // sequencer states
  typedef enum logic [2:0] {
    S_OFF,
    S_RESET,
    S_DISABLED,
    S_TRICKLE,
    S_FAST,
    S_COMPLETE,
    S_FAULT
  } css_state_t;
endpackage

// *** css_tmr_if.sv ***
// link between the sequencer and its charge-time counter
`timescale 1ns/10ps
interface css_tmr_if import css_pkg::*; ();
  logic                 clear;
  logic                 run;
  logic [OSC_DIV_W-1:0] div;
  logic                 osc_tick;
  logic                 half_tick;
  logic [TMR_W-1:0]     count;
  logic                 trickle_hit;
  logic                 full_hit;
  modport ctl (output clear, run, div,
               input  osc_tick, half_tick, count, trickle_hit, full_hit);
  modport tmr (input  clear, run, div,
               output osc_tick, half_tick, count, trickle_hit, full_hit);
endinterface

// *** css_timer.sv ***
// internal oscillator divider and charge-time counter
`timescale 1ns/10ps
module css_timer import css_pkg::*;
#(
  parameter int TIMEOUT_TICKS = TIMEOUT_OSC
)
(
  input wire logic clk,
  input wire logic rst_n,
  css_tmr_if.tmr   t
);
  localparam logic [TMR_W-1:0] FULL_LIM = TMR_W'(TIMEOUT_TICKS);
  localparam logic [TMR_W-1:0] TRK_LIM  = FULL_LIM >> TRICKLE_SHIFT;

  logic [OSC_DIV_W-1:0] div_cnt_q;
  logic [OSC_DIV_W-1:0] div_eff;
  logic [TMR_W-1:0]     cnt_q;

  // a divider below two would never give a half tick
  assign div_eff = (t.div < OSC_DIV_MIN) ? OSC_DIV_MIN : t.div;
  assign t.osc_tick  = (div_cnt_q == div_eff - 16'h0001);
  assign t.half_tick = (div_cnt_q == (div_eff >> 1) - 16'h0001);
  assign t.count       = cnt_q;
  assign t.trickle_hit = (cnt_q >= TRK_LIM);
  assign t.full_hit    = (cnt_q >= FULL_LIM);

  // free-running oscillator, never paused
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      div_cnt_q <= '0;
    else if (t.osc_tick || div_cnt_q >= div_eff)
      div_cnt_q <= '0;
    else
      div_cnt_q <= div_cnt_q + 16'h0001;
  end

  // charge-time counter: clear wins, saturates at the full limit
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      cnt_q <= '0;
    else if (t.clear)
      cnt_q <= '0;
    else if (t.run && t.osc_tick && !t.full_hit)
      cnt_q <= cnt_q + 23'h000001;
  end
endmodule

// *** css_sequencer.sv ***
// charge state sequencer: control state machine of a one-cell charger
`timescale 1ns/10ps
module css_sequencer import css_pkg::*;
#(
  parameter int TIMEOUT_TICKS = TIMEOUT_OSC
)
(
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              supply_ok,
  input  wire logic              charge_en,
  input  wire logic              timeout_gate_in,
  input  wire logic              vbat_above_pre,
  input  wire logic              eoc_det,
  input  wire logic              vbat_below_rechg,
  input  wire logic              temp_ok,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [31:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic [31:0]            reg_rdata,
  output logic                   charge_on,
  output logic                   trickle_mode,
  input  wire logic              status_pin_in,
  output logic                   status_pin_out,
  output logic                   status_pin_oe,
  input  wire logic              fault_pin_in,
  output logic                   fault_pin_out,
  output logic                   fault_pin_oe,
  output logic                   irq
);
  logic                 rst_meta_q;
  logic                 rst_sync_q;
  css_state_t           state_q;
  css_state_t           state_d;
  logic                 rechg_q;
  logic                 status_act_q;
  logic                 armed_q;
  logic                 temp_bad_q;
  logic                 status_want;
  logic                 chg_now;
  logic [OSC_DIV_W-1:0] osc_div_q;
  logic [IRQ_W-1:0]     irq_stat_q;
  logic [IRQ_W-1:0]     irq_mask_q;
  logic [IRQ_W-1:0]     irq_ev;
  logic [31:0]          rdata_q;
  logic                 charge_on_q;
  logic                 trickle_q;
  logic                 status_oe_q;
  logic                 fault_oe_q;
  logic                 irq_q;
  logic                 pin_low_q;

  css_tmr_if tm ();

  // true in the states that deliver current
  function automatic logic is_chg(input css_state_t s);
    is_chg = (s == S_TRICKLE) || (s == S_FAST) || (s == S_COMPLETE);
  endfunction

  // reset is released through two flip-flops
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  css_timer #(
    .TIMEOUT_TICKS (TIMEOUT_TICKS)
  ) u_timer (
    .clk   (clk),
    .rst_n (rst_sync_q),
    .t     (tm.tmr)
  );

  assign chg_now = is_chg(state_q);

  // next-state logic; loss of supply overrides everything
  always_comb
  begin
    state_d = state_q;
    if (!supply_ok)
      state_d = S_OFF;
    else
    begin
      unique case (state_q)
        S_OFF:
          state_d = S_RESET;
        S_RESET:
          state_d = charge_en ? S_TRICKLE : S_DISABLED;
        S_DISABLED:
          if (charge_en)
            state_d = S_TRICKLE;
        S_TRICKLE:
          if (!charge_en)
            state_d = S_DISABLED;
          else if (temp_ok && tm.trickle_hit)
            state_d = S_FAULT;
          else if (temp_ok && vbat_above_pre)
            state_d = S_FAST;
        S_FAST:
          if (!charge_en)
            state_d = S_DISABLED;
          else if (temp_ok && tm.full_hit && timeout_gate_in)
            state_d = S_FAULT;
          else if (temp_ok && eoc_det)
            state_d = S_COMPLETE;
        S_COMPLETE:
          if (!charge_en)
            state_d = S_DISABLED;
        S_FAULT:
          if (!charge_en)
            state_d = S_DISABLED;
        default:
          state_d = S_OFF;
      endcase
    end
  end

  // state register
  always_ff @(posedge clk or negedge rst_sync_q)
  begin
    if (!rst_sync_q)
      state_q <= S_OFF;
    else
      state_q <= state_d;
  end

  // counter cleared on internal reset and on trickle or fast entry
  assign tm.clear = (state_q == S_RESET)
    || (state_d == S_TRICKLE && state_q != S_TRICKLE)
    || (state_d == S_FAST && state_q != S_FAST);
  // counter paused while temperature is outside the window
  assign tm.run = ((state_q == S_TRICKLE) || (state_q == S_FAST))
    && temp_ok;
  assign tm.div = osc_div_q;

  // recharge request seen in complete; set wins over clear
  always_ff @(posedge clk or negedge rst_sync_q)
  begin
    if (!rst_sync_q)
      rechg_q <= 1'b0;
    else if (state_q != S_COMPLETE)
      rechg_q <= 1'b0;
    else if (vbat_below_rechg)
      rechg_q <= 1'b1;
    else if (eoc_det)
      rechg_q <= 1'b0;
  end

  assign status_want = chg_now && !(state_q == S_COMPLETE && !rechg_q);

  // status indication; end-of-charge and recharge changes filtered
  always_ff @(posedge clk or negedge rst_sync_q)
  begin
    if (!rst_sync_q)
    begin
      status_act_q <= 1'b0;
      armed_q      <= 1'b0;
    end
    else if (state_q != S_COMPLETE)
    begin
      status_act_q <= status_want;
      armed_q      <= 1'b0;
    end
    else if (status_want == status_act_q)
      armed_q <= 1'b0;
    else if (tm.half_tick)
      armed_q <= 1'b1;
    else if (tm.osc_tick && armed_q)
    begin
      status_act_q <= status_want;
      armed_q      <= 1'b0;
    end
  end

  // temperature pause tracking for the state register bit and its event
  always_ff @(posedge clk or negedge rst_sync_q)
  begin
    if (!rst_sync_q)
      temp_bad_q <= 1'b0;
    else
      temp_bad_q <= chg_now && !temp_ok;
  end

  // pin and mode outputs, all registered
  always_ff @(posedge clk or negedge rst_sync_q)
  begin
    if (!rst_sync_q)
    begin
      charge_on_q <= 1'b0;
      trickle_q   <= 1'b0;
      status_oe_q <= 1'b0;
      fault_oe_q  <= 1'b0;
      pin_low_q   <= 1'b0;
    end
    else
    begin
      charge_on_q <= chg_now && temp_ok;
      trickle_q   <= (state_q == S_TRICKLE) && temp_ok;
      status_oe_q <= status_act_q; // pulls the status pin low
      fault_oe_q  <= (state_q == S_FAULT)
        || (chg_now && !temp_ok);
      pin_low_q   <= 1'b0; // open-drain pins only ever drive low
    end
  end

  // events: fault entry, end of charge, recharge, temperature pause
  assign irq_ev[IRQ_FAULT] = (state_d == S_FAULT) && (state_q != S_FAULT);
  assign irq_ev[IRQ_EOC]   = (state_d == S_COMPLETE)
    && (state_q != S_COMPLETE);
  assign irq_ev[IRQ_RECHG] = (state_q == S_COMPLETE) && vbat_below_rechg
    && !rechg_q;
  assign irq_ev[IRQ_TEMP]  = chg_now && !temp_ok && !temp_bad_q;

  // sticky status, cleared by writing one; a new event wins
  always_ff @(posedge clk or negedge rst_sync_q)
  begin
    if (!rst_sync_q)
      irq_stat_q <= IRQ_STAT_RST;
    else if (reg_wr && reg_addr == ADDR_IRQ_STAT)
      irq_stat_q <= (irq_stat_q & ~reg_wdata[IRQ_W-1:0]) | irq_ev;
    else
      irq_stat_q <= irq_stat_q | irq_ev;
  end

  // writable registers: oscillator divider and interrupt mask
  always_ff @(posedge clk or negedge rst_sync_q)
  begin
    if (!rst_sync_q)
    begin
      osc_div_q  <= OSC_DIV_RST;
      irq_mask_q <= IRQ_MASK_RST;
    end
    else if (reg_wr)
    begin
      if (reg_addr == ADDR_OSC_DIV)
        osc_div_q <= reg_wdata[OSC_DIV_W-1:0];
      if (reg_addr == ADDR_IRQ_MASK)
        irq_mask_q <= reg_wdata[IRQ_W-1:0];
    end
  end

  // level interrupt from any unmasked status bit
  always_ff @(posedge clk or negedge rst_sync_q)
  begin
    if (!rst_sync_q)
      irq_q <= 1'b0;
    else
      irq_q <= |(irq_stat_q & irq_mask_q);
  end

  // read data stand for one cycle after the strobe, zero otherwise
  always_ff @(posedge clk or negedge rst_sync_q)
  begin
    if (!rst_sync_q)
      rdata_q <= '0;
    else if (!reg_rd)
      rdata_q <= '0;
    else
    begin
      rdata_q <= '0;
      unique case (reg_addr)
        ADDR_STATE:
        begin
          rdata_q[ST_STATE_LSB +: 3] <= 3'(state_q);
          rdata_q[ST_STATUS]         <= status_act_q;
          rdata_q[ST_FAULT]          <= fault_oe_q;
          rdata_q[ST_CHARGE]         <= charge_on_q;
          rdata_q[ST_RECHG]          <= rechg_q;
          rdata_q[ST_TEMP_BAD]       <= temp_bad_q;
          rdata_q[ST_STAT_PIN]       <= status_pin_in;
          rdata_q[ST_FAULT_PIN]      <= fault_pin_in;
        end
        ADDR_TIMER:
          rdata_q[TMR_W-1:0] <= tm.count;
        ADDR_OSC_DIV:
          rdata_q[OSC_DIV_W-1:0] <= osc_div_q;
        ADDR_IRQ_STAT:
          rdata_q[IRQ_W-1:0] <= irq_stat_q;
        ADDR_IRQ_MASK:
          rdata_q[IRQ_W-1:0] <= irq_mask_q;
        default:
          rdata_q <= '0;
      endcase
    end
  end

  assign reg_rdata      = rdata_q;
  assign charge_on      = charge_on_q;
  assign trickle_mode   = trickle_q;
  assign status_pin_out = pin_low_q;
  assign status_pin_oe  = status_oe_q;
  assign fault_pin_out  = pin_low_q;
  assign fault_pin_oe   = fault_oe_q;
  assign irq            = irq_q;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_sync_q);

  property p_por_reset;
    state_q == S_OFF && supply_ok |=> state_q == S_RESET ##1
      (!supply_ok || state_q != S_RESET);
  endproperty
  a_por_reset: assert property (p_por_reset)
    else $error("power-off did not pass through internal reset");

  property p_dis_hold;
    state_q == S_DISABLED && !charge_en && supply_ok |=>
      state_q == S_DISABLED ##1 !charge_on_q;
  endproperty
  a_dis_hold: assert property (p_dis_hold)
    else $error("disabled state left or charging with enable low");

  property p_reset_en;
    state_q == S_RESET && charge_en && supply_ok |=> state_q == S_TRICKLE;
  endproperty
  a_reset_en: assert property (p_reset_en)
    else $error("enabled reset did not start trickle charge");

  property p_trk_clear;
    $rose(state_q == S_TRICKLE) |-> tm.count == '0;
  endproperty
  a_trk_clear: assert property (p_trk_clear)
    else $error("counter not cleared on trickle entry");

  property p_trk_fast;
    state_q == S_TRICKLE && supply_ok && charge_en && temp_ok
      && !tm.trickle_hit && vbat_above_pre |=> state_q == S_FAST;
  endproperty
  a_trk_fast: assert property (p_trk_fast)
    else $error("trickle did not move to fast charge");

  property p_trk_fault;
    state_q == S_TRICKLE && supply_ok && charge_en && temp_ok
      && tm.trickle_hit |=> state_q == S_FAULT ##1 fault_pin_oe;
  endproperty
  a_trk_fault: assert property (p_trk_fault)
    else $error("trickle limit did not give a fault");

  property p_fault_hold;
    state_q == S_FAULT && charge_en && supply_ok |=> state_q == S_FAULT;
  endproperty
  a_fault_hold: assert property (p_fault_hold)
    else $error("fault left without enable toggle or supply cycle");

  property p_fast_clear;
    $rose(state_q == S_FAST) |-> tm.count == '0;
  endproperty
  a_fast_clear: assert property (p_fast_clear)
    else $error("counter not cleared on fast entry");

  property p_eoc;
    state_q == S_FAST && supply_ok && charge_en && temp_ok && eoc_det
      && !(tm.full_hit && timeout_gate_in) |=>
      state_q == S_COMPLETE ##1 (charge_on_q || !$past(temp_ok));
  endproperty
  a_eoc: assert property (p_eoc)
    else $error("end of charge did not reach complete with charge on");

  property p_rechg_pin;
    state_q == S_COMPLETE && status_act_q |=> status_pin_oe;
  endproperty
  a_rechg_pin: assert property (p_rechg_pin)
    else $error("recharge indication not driven on status pin");

  property p_gate;
    state_q == S_FAST && !timeout_gate_in |=> state_q != S_FAULT;
  endproperty
  a_gate: assert property (p_gate)
    else $error("fast timeout taken while gate low");

  property p_stat_delay;
    state_q == S_COMPLETE && $past(state_q) == S_COMPLETE
      && $changed(status_act_q) |-> $past(tm.osc_tick) && $past(armed_q);
  endproperty
  a_stat_delay: assert property (p_stat_delay)
    else $error("status changed without the oscillator delay");

  property p_temp;
    chg_now && !temp_ok && charge_en && supply_ok |=>
      !charge_on_q && fault_pin_oe && tm.count == $past(tm.count);
  endproperty
  a_temp: assert property (p_temp)
    else $error("temperature pause not applied");

  property p_fault_pin;
    (state_q == S_FAULT) != fault_oe_q && !temp_bad_q |->
      $past(state_q) != state_q || $past(chg_now && !temp_ok);
  endproperty
  a_fault_pin: assert property (p_fault_pin)
    else $error("fault pin does not follow the fault state");

  property p_dis;
    chg_now && !charge_en && supply_ok |=>
      state_q == S_DISABLED ##1 !charge_on_q;
  endproperty
  a_dis: assert property (p_dis)
    else $error("enable low did not stop charging");
endmodule

// *** css_sequencer_fix.sv ***
// spare file of the charge state sequencer; it holds no logic

// *** css_host_model.sv ***
// host logic: drives the enable inputs and pulls up the indicator pins
`timescale 1ns/10ps
module css_host_model
(
  input  wire logic en_cmd,
  input  wire logic gate_cmd,
  input  wire logic status_pin_out,
  input  wire logic status_pin_oe,
  input  wire logic fault_pin_out,
  input  wire logic fault_pin_oe,
  output logic      charge_en,
  output logic      timeout_gate_in,
  output logic      status_pin_in,
  output logic      fault_pin_in
);
  // an enable toggle or a supply cycle is the only way out of a latched fault
  assign charge_en       = en_cmd;
  // gate low drops the fast-charge limit only
  assign timeout_gate_in = gate_cmd;
  // external pull-ups hold released pins high
  assign status_pin_in   = status_pin_oe ? status_pin_out : 1'b1;
  assign fault_pin_in    = fault_pin_oe ? fault_pin_out : 1'b1;
endmodule

// *** tb_top.sv ***
// self-checking bench of the charge state sequencer
`timescale 1ns/10ps
module tb_top import css_pkg::*;;
  localparam int TT   = 64;
  localparam int OSCD = 4;
  logic              clk, rst_n, supply_ok, en_cmd, gate_cmd;
  logic              vbat_above_pre, eoc_det, vbat_below_rechg, temp_ok;
  logic              reg_wr, reg_rd;
  logic [ADDR_W-1:0] reg_addr;
  logic [31:0]       reg_wdata, reg_rdata, d, t1;
  logic              charge_on, trickle_mode, irq, charge_en, gate_in;
  logic              st_in, st_out, st_oe, fl_in, fl_out, fl_oe;
  int                n_errors, cmp_count, cyc, t0, el;

  css_sequencer #(.TIMEOUT_TICKS(TT)) i_dut (
    .clk(clk), .rst_n(rst_n), .supply_ok(supply_ok),
    .charge_en(charge_en), .timeout_gate_in(gate_in),
    .vbat_above_pre(vbat_above_pre), .eoc_det(eoc_det),
    .vbat_below_rechg(vbat_below_rechg), .temp_ok(temp_ok),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .charge_on(charge_on),
    .trickle_mode(trickle_mode), .status_pin_in(st_in),
    .status_pin_out(st_out), .status_pin_oe(st_oe),
    .fault_pin_in(fl_in), .fault_pin_out(fl_out),
    .fault_pin_oe(fl_oe), .irq(irq));

  css_host_model i_host (
    .en_cmd(en_cmd), .gate_cmd(gate_cmd), .status_pin_out(st_out),
    .status_pin_oe(st_oe), .fault_pin_out(fl_out), .fault_pin_oe(fl_oe),
    .charge_en(charge_en), .timeout_gate_in(gate_in),
    .status_pin_in(st_in), .fault_pin_in(fl_in));

  // clock and cycle count
  initial clk = 1'b0;
  always #2.5 clk = ~clk;
  initial cyc = 0;
  always @(posedge clk) cyc <= cyc + 1;

  // clock cycles that a number of oscillator periods lasts
  function automatic int osc_cycles(input int ticks);
    return ticks * OSCD;
  endfunction

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic reg_write(input logic [3:0] a, input logic [31:0] w);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= w;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask

  task automatic reg_read(input logic [3:0] a, output logic [31:0] r);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1;
    r = reg_rdata;
  endtask

  task automatic chk_state(input css_state_t s);
    logic [31:0] r;
    reg_read(ADDR_STATE, r);
    chk("state", 32'(s), {29'h0, r[2:0]});
  endtask

  // wait for an indicator pin level, then check the elapsed cycles
  task automatic wait_pin(input bit st, input logic v, input int lo,
                          input int hi, input string nm);
    t0 = cyc;
    while (((st ? st_in : fl_in) !== v) && (cyc - t0 < hi + 20))
      idle(1);
    el = cyc - t0;
    chk(nm, 32'h1, 32'(el >= lo && el <= hi));
  endtask

  // watchdog
  initial
  begin
    #(5 * 20000);
    n_errors++;
    stop_test();
  end

  initial
  begin
    rst_n = 1'b0; supply_ok = 1'b0; en_cmd = 1'b0; gate_cmd = 1'b1;
    vbat_above_pre = 1'b0; eoc_det = 1'b0; vbat_below_rechg = 1'b0;
    temp_ok = 1'b1; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = '0;
    reg_wdata = '0; n_errors = 0; cmp_count = 0;
    void'($urandom(32'hBAEB));
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    idle(3);
    // register reset values, unmapped index, mask access
    reg_read(ADDR_OSC_DIV, d);
    chk("osc_div reset", 32'(OSC_DIV_RST), d);
    reg_read(ADDR_IRQ_MASK, d);
    chk("mask reset", 32'(IRQ_MASK_RST), d);
    reg_read(4'hF, d);
    chk("unmapped", 32'h0, d);
    t1 = $urandom;
    reg_write(ADDR_IRQ_MASK, t1);
    reg_read(ADDR_IRQ_MASK, d);
    chk("mask rw", t1 & 32'hF, d);
    reg_write(ADDR_IRQ_MASK, 32'h0);
    chk_state(S_OFF);
    // power up with enable low
    supply_ok <= 1'b1;
    idle(5);
    chk_state(S_DISABLED);
    chk("charge off", 32'h0, 32'(charge_on));
    // power cycle with enable high
    supply_ok <= 1'b0;
    en_cmd    <= 1'b1;
    idle(3);
    chk_state(S_OFF);
    supply_ok <= 1'b1;
    idle(5);
    chk_state(S_TRICKLE);
    chk("trickle charge", 32'h3, {30'h0, charge_on, trickle_mode});
    chk("status on", 32'h0, 32'(st_in));
    en_cmd <= 1'b0;
    idle(4);
    chk_state(S_DISABLED);
    chk("charge stop", 32'h0, 32'(charge_on));
    reg_write(ADDR_OSC_DIV, 32'(OSCD));
    reg_write(ADDR_IRQ_STAT, 32'hF);
    // trickle runs out even with the gate low: fault after 1/8 limit
    en_cmd   <= 1'b1;
    gate_cmd <= 1'b0;
    wait_pin(0, 1'b0, osc_cycles(TT >> 3) - 6,
             osc_cycles(TT >> 3) + 10, "trickle limit");
    chk_state(S_FAULT);
    idle(60);
    chk_state(S_FAULT);
    chk("fault held", 32'h0, 32'(fl_in));
    // interrupt: set, masked, unmasked, cleared
    reg_read(ADDR_IRQ_STAT, d);
    chk("fault event", 32'h1, 32'(d[IRQ_FAULT]));
    chk("irq masked", 32'h0, 32'(irq));
    reg_write(ADDR_IRQ_MASK, 32'h1 << IRQ_FAULT);
    idle(2);
    chk("irq on", 32'h1, 32'(irq));
    reg_write(ADDR_IRQ_STAT, 32'h1 << IRQ_FAULT);
    idle(2);
    chk("irq cleared", 32'h0, 32'(irq));
    // enable toggle leaves the fault and restarts trickle
    en_cmd   <= 1'b0;
    gate_cmd <= 1'b1;
    idle(4);
    chk_state(S_DISABLED);
    chk("fault released", 32'h1, 32'(fl_in));
    en_cmd <= 1'b1;
    idle(8);
    reg_read(ADDR_TIMER, d);
    chk("trickle clear", 32'h1, 32'(d < 5));
    idle($urandom_range(6, 0));
    // battery passes threshold: fast charge, counter cleared
    vbat_above_pre <= 1'b1;
    idle(3);
    reg_read(ADDR_TIMER, d);
    chk("fast clear", 32'h1, 32'(d < 2));
    chk_state(S_FAST);
    wait_pin(0, 1'b0, osc_cycles(TT) - 14,
             osc_cycles(TT) + 12, "fast limit");
    chk_state(S_FAULT);
    // gate low: fast charge never times out
    gate_cmd <= 1'b0;
    en_cmd   <= 1'b0;
    idle(3);
    en_cmd   <= 1'b1;
    idle(12);
    chk_state(S_FAST);
    temp_ok <= 1'b0;
    idle(3);
    chk("temp fault", 32'h0, 32'(fl_in));
    reg_read(ADDR_TIMER, t1);
    idle(30);
    reg_read(ADDR_TIMER, d);
    chk("timer paused", t1, d);
    chk_state(S_FAST);
    temp_ok <= 1'b1;
    idle(osc_cycles(TT) + 100);
    chk_state(S_FAST);
    // end of charge: filtered status release, charging stays on
    eoc_det <= 1'b1;
    idle(2);
    chk("status held", 32'h0, 32'(st_in));
    wait_pin(1, 1'b1, 0, osc_cycles(2) + 4, "eoc delay");
    chk_state(S_COMPLETE);
    chk("charge stays", 32'h1, 32'(charge_on));
    reg_read(ADDR_IRQ_STAT, d);
    chk("eoc event", 32'h1, 32'(d[IRQ_EOC]));
    // recharge: status shows charging again
    eoc_det          <= 1'b0;
    vbat_below_rechg <= 1'b1;
    wait_pin(1, 1'b0, 2, osc_cycles(2) + 4, "rechg delay");
    chk_state(S_COMPLETE);
    // every event kind has been seen once since the last clear
    reg_read(ADDR_IRQ_STAT, d);
    chk("all events", 32'hF, d);
    // supply removed
    supply_ok <= 1'b0;
    idle(4);
    chk_state(S_OFF);
    chk("charge off", 32'h0, 32'(charge_on));
    stop_test();
  end
endmodule
